// File: core/emif_defs.svh
// Purpose: Constants for the external memory interface.
// Assumes: One machine cycle per clock at 100 MHz.
// Notes: Included by the package and by every design module.
`ifndef EMIF_DEFS_SVH
`define EMIF_DEFS_SVH

`define EMIF_ADDR_W 16
`define EMIF_DATA_W 16
`define EMIF_ROM_TOP 16'h3FFF
`define EMIF_DATA_EXT_BIT 15
`define EMIF_REGION_W 8
`define EMIF_SW_WAIT_W 3
`define EMIF_SW_WAIT_MAX 3'h7
`define EMIF_STRAP_SETTLE 2'h3
`define EMIF_IDLE_DATA 16'h0000

`define EMIF_SERVED_WRITE 2
`define EMIF_SERVED_READ 1
`define EMIF_SERVED_FETCH 0

`endif

// File: core/emif_pkg.sv
// Purpose: Types shared by the external memory interface modules.
// Assumes: Constants come from emif_defs.svh.
// Notes: Only types live here.
`include "emif_defs.svh"

package emif_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_WR_LEAD = 4'h4,
      ST_WR_DATA = 4'h8
   } bus_state_t;

   typedef enum logic [2:0] {
      KIND_FETCH = 3'h1,
      KIND_READ = 3'h2,
      KIND_WRITE = 3'h4
   } access_kind_t;

endpackage

// File: core/external_memory_interface.sv
// Purpose: Multiplexes fetch, data read and data write onto one external bus.
// Assumes: CPU holds its requests steady while cpu_stall is high.
// Notes: Internal targets complete with no external cycle.
`timescale 1ns/1ps
`default_nettype none
`include "emif_defs.svh"

module external_memory_interface (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fetch_req,
   input wire logic [`EMIF_ADDR_W-1:0] fetch_addr,
   input wire logic read_req,
   input wire logic [`EMIF_ADDR_W-1:0] read_addr,
   input wire logic read_io,
   input wire logic write_req,
   input wire logic [`EMIF_ADDR_W-1:0] write_addr,
   input wire logic [`EMIF_DATA_W-1:0] write_data,
   input wire logic write_io,
   input wire logic [`EMIF_REGION_W-1:0] global_region_register,
   input wire logic [`EMIF_SW_WAIT_W-1:0] sw_wait_states,
   input wire logic rom_select_pin,
   input wire logic ready,
   input wire logic [`EMIF_DATA_W-1:0] ext_data_in,
   output logic cpu_stall,
   output logic fetch_done,
   output logic read_done,
   output logic write_done,
   output logic [`EMIF_DATA_W-1:0] read_data,
   output logic rom_enable,
   output logic [`EMIF_ADDR_W-1:0] ext_address,
   output logic [`EMIF_DATA_W-1:0] ext_data_out,
   output logic ext_data_oe,
   output logic program_space_select_n,
   output logic data_space_select_n,
   output logic io_space_select_n,
   output logic read_not_write,
   output logic external_cycle_strobe_n,
   output logic global_bus_request_n
);

   // Pin synchronisers, three stages each
   logic [2:0] ready_sync;
   logic [2:0] strap_sync;
   logic ready_seen;
   logic strap_seen;
   logic [1:0] strap_count;
   logic strap_taken;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ready_sync <= 3'h0;
         strap_sync <= 3'h0;
         ready_seen <= 1'b0;
         strap_seen <= 1'b0;
      end else begin
         ready_sync <= {ready_sync[1:0], ready};
         strap_sync <= {strap_sync[1:0], rom_select_pin};
         if (ready_sync[1] == ready_sync[2]) begin
            ready_seen <= ready_sync[2];
         end
         if (strap_sync[1] == strap_sync[2]) begin
            strap_seen <= strap_sync[2];
         end
      end
   end

   // Strap caught once, shortly after reset release
   logic [1:0] next_strap_count;
   logic next_strap_taken;
   logic next_rom_enable;
   logic strap_now;

   // Strap level once the last two stages agree
   assign strap_now = (strap_sync[1] == strap_sync[2]) ? strap_sync[2] : strap_seen;

   always_comb begin
      next_strap_count = strap_count;
      next_strap_taken = strap_taken;
      next_rom_enable = rom_enable;
      if (!strap_taken) begin
         if (strap_count == `EMIF_STRAP_SETTLE) begin
            next_strap_taken = 1'b1;
            next_rom_enable = !strap_now;
         end else begin
            next_strap_count = strap_count + 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_count <= 2'h0;
         strap_taken <= 1'b0;
         rom_enable <= 1'b0;
      end else begin
         strap_count <= next_strap_count;
         strap_taken <= next_strap_taken;
         rom_enable <= next_rom_enable;
      end
   end

   // Address classification
   logic ext_w;
   logic ext_r;
   logic ext_f;
   logic glob_w;
   logic glob_r;

   function automatic logic is_global(input logic [`EMIF_ADDR_W-1:0] addr,
                                      input logic [`EMIF_REGION_W-1:0] region);
      logic upper;
      upper = addr[`EMIF_DATA_EXT_BIT];
      is_global = upper && (region != '0) &&
                  ((addr[`EMIF_ADDR_W-1:`EMIF_ADDR_W-`EMIF_REGION_W] & region) == region);
   endfunction

   // Lower data half belongs to on-chip peripherals
   assign ext_w = write_io || write_addr[`EMIF_DATA_EXT_BIT];
   assign ext_r = read_io || read_addr[`EMIF_DATA_EXT_BIT];
   assign ext_f = !(rom_enable && (fetch_addr <= `EMIF_ROM_TOP));
   assign glob_w = !write_io && is_global(write_addr, global_region_register);
   assign glob_r = !read_io && is_global(read_addr, global_region_register);

   // Access sequencer
   emif_pkg::bus_state_t state;
   emif_pkg::bus_state_t next_state;
   emif_pkg::access_kind_t kind;
   emif_pkg::access_kind_t next_kind;
   logic [2:0] served;
   logic [2:0] next_served;
   logic pend_w;
   logic pend_r;
   logic pend_f;
   logic release_access;
   logic wait_start;
   logic next_fetch_done;
   logic next_read_done;
   logic next_write_done;
   logic [`EMIF_DATA_W-1:0] next_read_data;
   logic [`EMIF_ADDR_W-1:0] next_ext_address;
   logic [`EMIF_DATA_W-1:0] next_ext_data_out;
   logic next_ext_data_oe;
   logic next_prog_n;
   logic next_data_n;
   logic next_io_n;
   logic next_read_not_write;
   logic next_strobe_n;
   logic next_request_n;

   assign pend_w = write_req && !served[`EMIF_SERVED_WRITE];
   assign pend_r = read_req && !served[`EMIF_SERVED_READ];
   assign pend_f = fetch_req && !served[`EMIF_SERVED_FETCH];
   assign cpu_stall = pend_w || pend_r || pend_f;
   assign wait_start = (state == emif_pkg::ST_IDLE) || (state == emif_pkg::ST_WR_LEAD);

   wait_gate u_wait_gate (
      .clock(clock),
      .rst_n(rst_n),
      .start(wait_start),
      .sw_wait_states(sw_wait_states),
      .ready_seen(ready_seen),
      .release_access(release_access)
   );

   always_comb begin
      next_state = state;
      next_kind = kind;
      next_served = cpu_stall ? served : 3'h0;
      next_fetch_done = 1'b0;
      next_read_done = 1'b0;
      next_write_done = 1'b0;
      next_read_data = read_data;
      next_ext_address = ext_address;
      next_ext_data_out = ext_data_out;
      next_ext_data_oe = ext_data_oe;
      next_prog_n = program_space_select_n;
      next_data_n = data_space_select_n;
      next_io_n = io_space_select_n;
      next_read_not_write = read_not_write;
      next_strobe_n = external_cycle_strobe_n;
      next_request_n = global_bus_request_n;
      case (state)
         emif_pkg::ST_IDLE: begin
            if (pend_w) begin
               if (ext_w) begin
                  next_state = emif_pkg::ST_WR_LEAD;
                  next_kind = emif_pkg::KIND_WRITE;
                  next_ext_address = write_addr;
                  next_ext_data_out = write_data;
                  next_data_n = write_io;
                  next_io_n = !write_io;
                  next_read_not_write = 1'b0;
                  next_strobe_n = 1'b0;
                  next_request_n = !glob_w;
               end else begin
                  next_served[`EMIF_SERVED_WRITE] = 1'b1;
                  next_write_done = 1'b1;
               end
            end else if (pend_r) begin
               if (ext_r) begin
                  next_state = emif_pkg::ST_READ;
                  next_kind = emif_pkg::KIND_READ;
                  next_ext_address = read_addr;
                  next_data_n = read_io;
                  next_io_n = !read_io;
                  next_read_not_write = 1'b1;
                  next_strobe_n = 1'b0;
                  next_request_n = !glob_r;
               end else begin
                  next_served[`EMIF_SERVED_READ] = 1'b1;
                  next_read_done = 1'b1;
               end
            end else if (pend_f) begin
               if (ext_f) begin
                  next_state = emif_pkg::ST_READ;
                  next_kind = emif_pkg::KIND_FETCH;
                  next_ext_address = fetch_addr;
                  next_prog_n = 1'b0;
                  next_read_not_write = 1'b1;
                  next_strobe_n = 1'b0;
               end else begin
                  next_served[`EMIF_SERVED_FETCH] = 1'b1;
                  next_fetch_done = 1'b1;
               end
            end
         end
         emif_pkg::ST_READ: begin
            if (release_access) begin
               next_state = emif_pkg::ST_IDLE;
               next_read_data = ext_data_in;
               if (kind == emif_pkg::KIND_FETCH) begin
                  next_served[`EMIF_SERVED_FETCH] = 1'b1;
                  next_fetch_done = 1'b1;
               end else begin
                  next_served[`EMIF_SERVED_READ] = 1'b1;
                  next_read_done = 1'b1;
               end
               next_prog_n = 1'b1;
               next_data_n = 1'b1;
               next_io_n = 1'b1;
               next_strobe_n = 1'b1;
               next_request_n = 1'b1;
            end
         end
         emif_pkg::ST_WR_LEAD: begin
            // Bus left undriven one cycle to avoid contention
            next_state = emif_pkg::ST_WR_DATA;
            next_ext_data_oe = 1'b1;
         end
         emif_pkg::ST_WR_DATA: begin
            if (release_access) begin
               next_state = emif_pkg::ST_IDLE;
               next_served[`EMIF_SERVED_WRITE] = 1'b1;
               next_write_done = 1'b1;
               next_ext_data_oe = 1'b0;
               next_data_n = 1'b1;
               next_io_n = 1'b1;
               next_strobe_n = 1'b1;
               next_request_n = 1'b1;
               next_read_not_write = 1'b1;
            end
         end
         default: begin
            next_state = emif_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= emif_pkg::ST_IDLE;
         kind <= emif_pkg::KIND_FETCH;
         served <= 3'h0;
         fetch_done <= 1'b0;
         read_done <= 1'b0;
         write_done <= 1'b0;
         read_data <= `EMIF_IDLE_DATA;
         ext_address <= 16'h0000;
         ext_data_out <= `EMIF_IDLE_DATA;
         ext_data_oe <= 1'b0;
         program_space_select_n <= 1'b1;
         data_space_select_n <= 1'b1;
         io_space_select_n <= 1'b1;
         read_not_write <= 1'b1;
         external_cycle_strobe_n <= 1'b1;
         global_bus_request_n <= 1'b1;
      end else begin
         state <= next_state;
         kind <= next_kind;
         served <= next_served;
         fetch_done <= next_fetch_done;
         read_done <= next_read_done;
         write_done <= next_write_done;
         read_data <= next_read_data;
         ext_address <= next_ext_address;
         ext_data_out <= next_ext_data_out;
         ext_data_oe <= next_ext_data_oe;
         program_space_select_n <= next_prog_n;
         data_space_select_n <= next_data_n;
         io_space_select_n <= next_io_n;
         read_not_write <= next_read_not_write;
         external_cycle_strobe_n <= next_strobe_n;
         global_bus_request_n <= next_request_n;
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_one_select;
      !external_cycle_strobe_n |->
         $onehot({!program_space_select_n, !data_space_select_n, !io_space_select_n});
   endproperty
   a_one_select: assert property (p_one_select) else $error("space selects not one-hot");

   property p_idle_quiet;
      state == emif_pkg::ST_IDLE |-> external_cycle_strobe_n && program_space_select_n &&
         data_space_select_n && io_space_select_n && !ext_data_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("bus active while idle");

   property p_strobe_in_cycle;
      state != emif_pkg::ST_IDLE |-> !external_cycle_strobe_n;
   endproperty
   a_strobe_in_cycle: assert property (p_strobe_in_cycle) else $error("strobe missing");

   property p_write_two;
      state == emif_pkg::ST_WR_LEAD |-> !ext_data_oe && !read_not_write
         ##1 state == emif_pkg::ST_WR_DATA && ext_data_oe;
   endproperty
   a_write_two: assert property (p_write_two) else $error("write phases wrong");

   property p_read_zero_wait;
      state == emif_pkg::ST_IDLE ##1 state == emif_pkg::ST_READ && release_access
         |=> state == emif_pkg::ST_IDLE && (read_done || fetch_done);
   endproperty
   a_read_zero_wait: assert property (p_read_zero_wait) else $error("read not one cycle");

   property p_hold_without_ready;
      state == emif_pkg::ST_READ && !ready_seen |=> state == emif_pkg::ST_READ;
   endproperty
   a_hold_without_ready: assert property (p_hold_without_ready) else $error("ended without ready");

   property p_write_first;
      state == emif_pkg::ST_IDLE && pend_w && ext_w
         |=> state == emif_pkg::ST_WR_LEAD && kind == emif_pkg::KIND_WRITE;
   endproperty
   a_write_first: assert property (p_write_first) else $error("write not served first");

   property p_read_before_fetch;
      state == emif_pkg::ST_IDLE && !pend_w && pend_r && ext_r && pend_f
         |=> kind == emif_pkg::KIND_READ;
   endproperty
   a_read_before_fetch: assert property (p_read_before_fetch) else $error("fetch overtook read");

   property p_global_request;
      !global_bus_request_n |-> !data_space_select_n && ext_address[`EMIF_DATA_EXT_BIT];
   endproperty
   a_global_request: assert property (p_global_request) else $error("request off data space");

   property p_data_upper;
      !data_space_select_n |-> ext_address[`EMIF_DATA_EXT_BIT];
   endproperty
   a_data_upper: assert property (p_data_upper) else $error("external data below 32K");

   property p_rom_hidden;
      !program_space_select_n && rom_enable |-> ext_address > `EMIF_ROM_TOP;
   endproperty
   a_rom_hidden: assert property (p_rom_hidden) else $error("ROM address went external");

   property p_strap_stable;
      strap_taken |=> strap_taken && $stable(rom_enable);
   endproperty
   a_strap_stable: assert property (p_strap_stable) else $error("ROM enable changed");

   c_write: cover property (state == emif_pkg::ST_WR_DATA && release_access);
   c_global_read: cover property (state == emif_pkg::ST_READ && !global_bus_request_n);
   c_long_wait: cover property (state == emif_pkg::ST_READ [*6] ##1 read_done);
   c_three_way: cover property (state == emif_pkg::ST_IDLE && pend_w && pend_r && pend_f);

endmodule // external_memory_interface

`default_nettype wire

// File: core/wait_gate.sv
// Purpose: Ends an external access once both wait sources allow it.
// Assumes: start stays high until the cycle that enters a counted access phase.
// Notes: Software count saturates at its maximum.
`timescale 1ns/1ps
`default_nettype none
`include "emif_defs.svh"

module wait_gate (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [`EMIF_SW_WAIT_W-1:0] sw_wait_states,
   input wire logic ready_seen,
   output logic release_access
);

   logic [`EMIF_SW_WAIT_W-1:0] count;
   logic [`EMIF_SW_WAIT_W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (start) begin
         next_count = '0;
      end else if (count != `EMIF_SW_WAIT_MAX) begin
         next_count = count + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Both software count and ready must agree
   assign release_access = (count >= sw_wait_states) && ready_seen;

   property p_sw_wait;
      @(posedge clock) disable iff (!rst_n)
      start |=> !release_access || (sw_wait_states == 3'h0);
   endproperty
   a_sw_wait: assert property (p_sw_wait) else $error("release before waits satisfied");

   property p_count_restart;
      @(posedge clock) disable iff (!rst_n)
      start |=> count == 3'h0;
   endproperty
   a_count_restart: assert property (p_count_restart) else $error("wait count not cleared");

endmodule // wait_gate

`default_nettype wire

// File: verification/ext_memory_model.sv
// Purpose: Far-side memories, I/O devices and global arbiter.
// Assumes: Bus driven by external_memory_interface.
// Notes: Ready idles low whenever waits are asked for.
`timescale 1ns/1ps
`default_nettype none

module ext_memory_model #(
   parameter int ARB_CYCLES = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] wait_cycles,
   input wire logic [15:0] address,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic program_space_select_n,
   input wire logic io_space_select_n,
   input wire logic read_not_write,
   input wire logic external_cycle_strobe_n,
   input wire logic global_bus_request_n,
   output logic ready,
   output logic [15:0] data_in,
   output logic [15:0] wr_data
);
   logic [4:0] cycles;
   logic [4:0] need;
   logic [15:0] idle_val;
   logic [15:0] pattern;

   always_comb begin
      pattern = address ^ (!program_space_select_n ? 16'h5A00 :
                           !io_space_select_n ? 16'h0FF0 : 16'hA500);
      need = {1'h0, wait_cycles} + (global_bus_request_n ? 5'h00 : 5'(ARB_CYCLES));
      ready = (wait_cycles == 4'h0) || (!external_cycle_strobe_n && cycles >= need);
      // Released bus shows the inverse of its last value
      data_in = (!external_cycle_strobe_n && read_not_write) ? pattern : idle_val;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cycles <= 5'h00;
         idle_val <= 16'h0000;
         wr_data <= 16'h0000;
      end else begin
         idle_val <= ~data_in;
         cycles <= external_cycle_strobe_n ? 5'h00 : cycles + {4'h0, cycles != 5'h1F};
         if (!external_cycle_strobe_n && data_oe && !read_not_write) begin
            wr_data <= data_out;
         end
      end
   end
endmodule // ext_memory_model

`default_nettype wire

// File: verification/external_memory_interface_bench.sv
// Purpose: Self-checking bench for external_memory_interface.
// Assumes: ext_memory_model answers on the far side.
// Notes: Ordinary accesses come from a row table.
`timescale 1ns/1ps
`default_nettype none

module external_memory_interface_bench;
   typedef struct packed {
      logic [1:0] kind;
      logic [15:0] addr;
      logic io;
      logic [7:0] region;
      logic [2:0] sw;
      logic ext;
      logic [2:0] sel;
      logic glob;
   } row_t;
   // Kind 2 write, 1 read, 0 fetch; sel is {program, data, io} active low
   localparam row_t ROWS [13] = '{
      '{2'h0, 16'h4000, 1'h0, 8'h00, 3'h0, 1'h1, 3'h3, 1'h0},
      '{2'h0, 16'h0100, 1'h0, 8'h00, 3'h0, 1'h0, 3'h7, 1'h0},
      '{2'h0, 16'hFFFF, 1'h0, 8'h00, 3'h2, 1'h1, 3'h3, 1'h0},
      '{2'h1, 16'h8000, 1'h0, 8'h00, 3'h0, 1'h1, 3'h5, 1'h0},
      '{2'h1, 16'h0200, 1'h0, 8'h00, 3'h0, 1'h0, 3'h7, 1'h0},
      '{2'h1, 16'h0200, 1'h1, 8'h00, 3'h0, 1'h1, 3'h6, 1'h0},
      '{2'h1, 16'hF000, 1'h0, 8'hC0, 3'h0, 1'h1, 3'h5, 1'h1},
      '{2'h1, 16'h9000, 1'h0, 8'hC0, 3'h0, 1'h1, 3'h5, 1'h0},
      '{2'h1, 16'h8004, 1'h0, 8'h00, 3'h3, 1'h1, 3'h5, 1'h0},
      '{2'h2, 16'hC000, 1'h0, 8'hC0, 3'h0, 1'h1, 3'h5, 1'h1},
      '{2'h2, 16'hFF0F, 1'h1, 8'hC0, 3'h0, 1'h1, 3'h6, 1'h0},
      '{2'h2, 16'h8010, 1'h0, 8'h00, 3'h7, 1'h1, 3'h5, 1'h0},
      '{2'h2, 16'h1000, 1'h0, 8'h00, 3'h0, 1'h0, 3'h7, 1'h0}};

   logic clock, rst_n, fetch_req, read_req, read_io, write_req, write_io, rom_select_pin, ready;
   logic [15:0] fetch_addr, read_addr, write_addr, write_data, ext_data_in, read_data;
   logic [15:0] ext_address, ext_data_out, wr_data;
   logic [7:0] global_region_register;
   logic [2:0] sw_wait_states, sel_seen;
   logic [3:0] mem_wait;
   logic cpu_stall, fetch_done, read_done, write_done, rom_enable, ext_data_oe, read_not_write;
   logic program_space_select_n, data_space_select_n, io_space_select_n;
   logic external_cycle_strobe_n, global_bus_request_n, rnw_seen, glob_seen, strobe_prev;
   int errors, cmp_count, strobes, bad, cycles, exp;
   logic [15:0] acc_addr [$];
   int order [$];

   external_memory_interface DUT (.clock(clock), .rst_n(rst_n), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .read_req(read_req), .read_addr(read_addr), .read_io(read_io),
      .write_req(write_req), .write_addr(write_addr), .write_data(write_data),
      .write_io(write_io), .global_region_register(global_region_register),
      .sw_wait_states(sw_wait_states), .rom_select_pin(rom_select_pin), .ready(ready),
      .ext_data_in(ext_data_in), .cpu_stall(cpu_stall), .fetch_done(fetch_done),
      .read_done(read_done), .write_done(write_done), .read_data(read_data),
      .rom_enable(rom_enable), .ext_address(ext_address), .ext_data_out(ext_data_out),
      .ext_data_oe(ext_data_oe), .program_space_select_n(program_space_select_n),
      .data_space_select_n(data_space_select_n), .io_space_select_n(io_space_select_n),
      .read_not_write(read_not_write), .external_cycle_strobe_n(external_cycle_strobe_n),
      .global_bus_request_n(global_bus_request_n));

   ext_memory_model memory (.clock(clock), .rst_n(rst_n), .wait_cycles(mem_wait),
      .address(ext_address), .data_out(ext_data_out), .data_oe(ext_data_oe),
      .program_space_select_n(program_space_select_n), .io_space_select_n(io_space_select_n),
      .read_not_write(read_not_write), .external_cycle_strobe_n(external_cycle_strobe_n),
      .global_bus_request_n(global_bus_request_n), .ready(ready), .data_in(ext_data_in),
      .wr_data(wr_data));

   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   // Bus watcher on settled values
   always @(negedge clock) begin
      if (external_cycle_strobe_n === 1'h0) begin
         strobes++;
         if (strobe_prev) acc_addr.push_back(ext_address);
         if (strobe_prev && ext_data_oe !== 1'h0) bad++;
         sel_seen = {program_space_select_n, data_space_select_n, io_space_select_n};
         rnw_seen = read_not_write;
         glob_seen = glob_seen | !global_bus_request_n;
         if ($countones(~sel_seen) != 1 || ext_address !== acc_addr[$]) bad++;
      end else if ({program_space_select_n, data_space_select_n, io_space_select_n,
                    global_bus_request_n, ext_data_oe} !== 5'h1E) begin
         bad++;
      end
      strobe_prev = external_cycle_strobe_n;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         $display("unexpected %0t run too long", $time);
         stop_test();
      end
   end

   task automatic stop_test;
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check_val(input logic [15:0] got, input logic [15:0] want, input string what);
      cmp_count++;
      if (got !== want) begin
         errors++;
         $display("unexpected %0t %s got %h want %h", $time, what, got, want);
      end
   endtask

   task automatic check_range(input int got, input int lo, input int hi, input string what);
      cmp_count++;
      if (got < lo || got > hi) begin
         errors++;
         $display("unexpected %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
      end
   endtask

   task automatic do_reset(input logic strap);
      rst_n <= 1'h0;
      rom_select_pin <= strap;
      repeat (10) @(posedge clock);
      rst_n <= 1'h1;
      repeat (6) @(posedge clock);
      check_val(rom_enable, !strap, "rom enable");
   endtask

   // Raises the masked requests together and collects done order
   task automatic go(input logic [2:0] mask);
      logic [2:0] seen;
      seen = 3'h0;
      repeat (4) @(posedge clock);
      order = '{};
      acc_addr = '{};
      strobes = 0;
      glob_seen = 1'h0;
      @(posedge clock);
      write_req <= mask[2];
      read_req <= mask[1];
      fetch_req <= mask[0];
      for (int n = 0; n < 400 && seen != mask; n++) begin
         @(negedge clock);
         if (n == 0) check_val(cpu_stall, 1'h1, "stall raised");
         if (write_done === 1'h1) order.push_back(2);
         if (read_done === 1'h1) order.push_back(1);
         if (fetch_done === 1'h1) order.push_back(0);
         seen = seen | {write_done === 1'h1, read_done === 1'h1, fetch_done === 1'h1};
      end
      check_val(seen, mask, "done pulses");
      check_val(cpu_stall, 1'h0, "stall released");
      @(posedge clock);
      write_req <= 1'h0;
      read_req <= 1'h0;
      fetch_req <= 1'h0;
      @(posedge clock);
   endtask

   task automatic run(input logic [1:0] kind, input logic [15:0] a, input logic io,
                      input logic [7:0] region, input logic [2:0] sw);
      global_region_register <= region;
      sw_wait_states <= sw;
      fetch_addr <= a;
      read_addr <= a;
      write_addr <= a;
      write_data <= ~a;
      read_io <= io;
      write_io <= io;
      go(3'h1 << kind);
   endtask

   initial begin
      {fetch_req, read_req, write_req, read_io, write_io, rst_n} = 6'h00;
      {fetch_addr, read_addr, write_addr, write_data} = 64'h0;
      global_region_register = 8'h00;
      sw_wait_states = 3'h0;
      rom_select_pin = 1'h0;
      mem_wait = 4'h0;
      strobe_prev = 1'h1;
      do_reset(1'h0);
      foreach (ROWS[i]) begin
         run(ROWS[i].kind, ROWS[i].addr, ROWS[i].io, ROWS[i].region, ROWS[i].sw);
         exp = ROWS[i].ext ? (ROWS[i].kind == 2'h2 ? 2 : 1) + ROWS[i].sw : 0;
         check_range(strobes, exp, exp, "strobe cycles");
         if (ROWS[i].ext) begin
            check_val(sel_seen, ROWS[i].sel, "space select");
            check_val(glob_seen, ROWS[i].glob, "bus request");
            check_val(rnw_seen, ROWS[i].kind != 2'h2, "read write");
            check_val(acc_addr[0], ROWS[i].addr, "address");
            if (ROWS[i].kind == 2'h2) begin
               check_val(wr_data, ~ROWS[i].addr, "write data");
            end else begin
               check_val(read_data, ROWS[i].addr ^ (ROWS[i].sel == 3'h3 ? 16'h5A00 :
                  ROWS[i].io ? 16'h0FF0 : 16'hA500), "read data");
            end
         end
      end
      write_addr <= 16'h8010;
      read_addr <= 16'h8020;
      fetch_addr <= 16'h5000;
      read_io <= 1'h0;
      write_io <= 1'h0;
      sw_wait_states <= 3'h0;
      go(3'h7);
      check_range(order.size() == 3 ? order[0] * 16 + order[1] * 4 + order[2] : -1,
                  36, 36, "serve order");
      check_val(acc_addr[1], 16'h8020, "second access");
      check_val(acc_addr[2], 16'h5000, "third access");
      check_range(strobes, 4, 4, "strobe cycles");
      mem_wait <= 4'h6;
      run(2'h1, 16'h8000, 1'h0, 8'h00, 3'h0);
      check_range(strobes, 11, 11, "ready waits");
      check_val(read_data, 16'h2500, "waited read");
      run(2'h1, 16'hF000, 1'h0, 8'hC0, 3'h0);
      check_range(strobes, 13, 13, "global wait");
      run(2'h2, 16'h8030, 1'h0, 8'h00, 3'h0);
      check_range(strobes, 11, 11, "write wait");
      check_val(wr_data, 16'h7FCF, "waited write");
      mem_wait <= 4'h1;
      run(2'h1, 16'h8040, 1'h0, 8'h00, 3'h3);
      check_range(strobes, 6, 6, "both wait sources");
      mem_wait <= 4'h0;
      do_reset(1'h1);
      run(2'h0, 16'h0100, 1'h0, 8'h00, 3'h0);
      check_range(strobes, 1, 1, "external fetch");
      check_val(read_data, 16'h5B00, "fetch data");
      do_reset(1'h0);
      check_range(bad, 0, 0, "bus protocol");
      stop_test();
   end
endmodule // external_memory_interface_bench

`default_nettype wire
